// ===== design/staged_watchdog.sv
// Staged boot and runtime watchdog: boot-phase timer and three-stage runtime timer.
`timescale 1ns/1ps
`include "wdt_defines.svh"
module staged_watchdog #(
    parameter int unsigned TICK_CYCLES = `SEC_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire wdt_pkg::wdt_cfg_t cfg,
    input wire logic post_active,
    input wire logic user_wait,
    input wire logic os_boot_start,
    input wire logic retrigger,
    output logic sys_reset,
    output logic pwr_button,
    output logic thermal_notify,
    output logic fatal_error,
    output logic runtime_active,
    output logic [1:0] stage
);
    import wdt_pkg::*;

    if (TICK_CYCLES < 2) begin : g_bad
        $error("staged_watchdog needs at least two cycles per second tick.");
    end

    // ****************************************
    // Lookup functions
    // ****************************************
    function automatic logic [10:0] stage_secs(input logic [3:0] sel);
        case (sel)
            4'h0: stage_secs = `SECS_1S;
            4'h1: stage_secs = `SECS_2S;
            4'h2: stage_secs = `SECS_5S;
            4'h3: stage_secs = `SECS_10S;
            4'h5: stage_secs = `SECS_1M;
            4'h6: stage_secs = `SECS_2M;
            4'h7: stage_secs = `SECS_5M;
            4'h8: stage_secs = `SECS_10M;
            4'h9: stage_secs = `SECS_30M;
            default: stage_secs = `SECS_30S;
        endcase
    endfunction

    function automatic logic [10:0] delay_secs(input logic [2:0] sel);
        case (sel)
            3'h1: delay_secs = `SECS_10S;
            3'h2: delay_secs = `SECS_30S;
            3'h3: delay_secs = `SECS_1M;
            3'h4: delay_secs = `SECS_2M;
            3'h5: delay_secs = `SECS_5M;
            3'h6: delay_secs = `SECS_10M;
            default: delay_secs = `SECS_30M;
        endcase
    endfunction

    function automatic logic [10:0] post_secs(input logic [2:0] sel);
        case (sel)
            3'h1: post_secs = `SECS_30S;
            3'h2: post_secs = `SECS_1M;
            3'h3: post_secs = `SECS_2M;
            3'h4: post_secs = `SECS_5M;
            3'h5: post_secs = `SECS_10M;
            default: post_secs = `SECS_30M;
        endcase
    endfunction

    // Stage one cannot be disabled, so a disabled code there falls back to reset.
    function automatic act_t stage_act(input logic [1:0] s, input wdt_cfg_t c);
        case (s)
            2'h1: stage_act = (c.event1 == ACT_OFF) ? ACT_RESET : c.event1;
            2'h2: stage_act = c.event2;
            2'h3: stage_act = c.event3;
            default: stage_act = ACT_OFF;
        endcase
    endfunction

    function automatic logic [10:0] stage_tout(input logic [1:0] s, input wdt_cfg_t c);
        case (s)
            2'h2: stage_tout = stage_secs(c.tout2);
            2'h3: stage_tout = stage_secs(c.tout3);
            default: stage_tout = stage_secs(c.tout1);
        endcase
    endfunction

    // ****************************************
    // Boot-phase watchdog
    // ****************************************
    logic post_tick;
    logic post_clear;
    logic post_run;
    logic post_fire;
    logic [10:0] post_cnt_reg;
    logic [10:0] post_cnt_next;

    // A halted or idle timer also restarts its second so the next run gets whole seconds.
    assign post_run = post_active && (cfg.post_sel != 3'h0)
                      && !(cfg.pause_en && user_wait);
    assign post_clear = !post_run;

    tick_divider #(.CYCLES(TICK_CYCLES)) u_post_div (
        .clock(clock),
        .rst_n(rst_n),
        .clear(post_clear),
        .tick(post_tick)
    );

    always_comb begin
        post_cnt_next = post_cnt_reg;
        post_fire = 1'b0;
        if (!post_active || cfg.post_sel == 3'h0) begin
            post_cnt_next = post_secs(cfg.post_sel);
        end else if (post_run && post_tick) begin
            if (post_cnt_reg <= 11'h001) begin
                post_fire = 1'b1;
                post_cnt_next = post_secs(cfg.post_sel);
            end else begin
                post_cnt_next = post_cnt_reg - 11'h001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            post_cnt_reg <= `SECS_30M;
        end else begin
            post_cnt_reg <= post_cnt_next;
        end
    end

    // ****************************************
    // Runtime watchdog
    // ****************************************
    rt_state_t rt_state_reg;
    rt_state_t rt_state_next;
    logic [1:0] stage_reg;
    logic [1:0] stage_next;
    logic [10:0] rt_cnt_reg;
    logic [10:0] rt_cnt_next;
    logic rt_tick;
    logic rt_clear;
    logic last_stage;
    logic expire;
    act_t fire_act;

    tick_divider #(.CYCLES(TICK_CYCLES)) u_rt_div (
        .clock(clock),
        .rst_n(rst_n),
        .clear(rt_clear),
        .tick(rt_tick)
    );

    assign last_stage = (stage_reg == 2'h3)
                        || (stage_act(2'(stage_reg + 2'h1), cfg) == ACT_OFF);
    assign expire = (rt_state_reg == RT_RUN) && !retrigger && cfg.mode != MODE_OFF
                    && rt_tick && rt_cnt_reg <= 11'h001;

    always_comb begin
        rt_state_next = rt_state_reg;
        stage_next = stage_reg;
        rt_cnt_next = rt_cnt_reg;
        rt_clear = 1'b0;
        fire_act = ACT_OFF;
        case (rt_state_reg)
            RT_OFF: begin
                if (os_boot_start && cfg.mode != MODE_OFF) begin
                    rt_clear = 1'b1;
                    stage_next = 2'h1;
                    if (cfg.delay_sel != 3'h0) begin
                        rt_state_next = RT_DELAY;
                        rt_cnt_next = delay_secs(cfg.delay_sel);
                    end else begin
                        rt_state_next = RT_RUN;
                        rt_cnt_next = stage_tout(2'h1, cfg);
                    end
                end
            end
            RT_DELAY: begin
                if (cfg.mode == MODE_OFF) begin
                    rt_state_next = RT_OFF;
                end else if (rt_tick) begin
                    if (rt_cnt_reg <= 11'h001) begin
                        rt_state_next = RT_RUN;
                        rt_cnt_next = stage_tout(2'h1, cfg);
                    end else begin
                        rt_cnt_next = rt_cnt_reg - 11'h001;
                    end
                end
            end
            RT_RUN: begin
                if (cfg.mode == MODE_OFF) begin
                    rt_state_next = RT_OFF;
                end else if (retrigger) begin
                    rt_clear = 1'b1;
                    if (cfg.mode == MODE_ONE) begin
                        rt_state_next = RT_OFF;
                    end else begin
                        stage_next = 2'h1;
                        rt_cnt_next = stage_tout(2'h1, cfg);
                    end
                end else if (expire) begin
                    fire_act = stage_act(stage_reg, cfg);
                    if (!last_stage) begin
                        stage_next = 2'(stage_reg + 2'h1);
                        rt_cnt_next = stage_tout(2'(stage_reg + 2'h1), cfg);
                    end else if (cfg.mode == MODE_REPEAT) begin
                        rt_cnt_next = stage_tout(stage_reg, cfg);
                    end else begin
                        rt_state_next = RT_OFF;
                    end
                end else if (rt_tick) begin
                    rt_cnt_next = rt_cnt_reg - 11'h001;
                end
            end
            default: rt_state_next = RT_OFF;
        endcase
    end

    // ****************************************
    // Action outputs
    // ****************************************
    logic sys_reset_reg;
    logic pwr_button_reg;
    logic thermal_reg;
    logic fatal_reg;
    logic active_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rt_state_reg <= RT_OFF;
            stage_reg <= 2'h0;
            rt_cnt_reg <= `SECS_30S;
            sys_reset_reg <= 1'b0;
            pwr_button_reg <= 1'b0;
            thermal_reg <= 1'b0;
            fatal_reg <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            rt_state_reg <= rt_state_next;
            stage_reg <= (rt_state_next == RT_OFF) ? 2'h0 : stage_next;
            rt_cnt_reg <= rt_cnt_next;
            sys_reset_reg <= post_fire || fire_act == ACT_RESET;
            pwr_button_reg <= fire_act == ACT_PWRBTN;
            thermal_reg <= fire_act == ACT_ACPI && !cfg.acpi_restart;
            fatal_reg <= fire_act == ACT_ACPI && cfg.acpi_restart;
            active_reg <= rt_state_next == RT_RUN;
        end
    end

    assign sys_reset = sys_reset_reg;
    assign pwr_button = pwr_button_reg;
    assign thermal_notify = thermal_reg;
    assign fatal_error = fatal_reg;
    assign runtime_active = active_reg;
    assign stage = stage_reg;

    // ****************************************
    // Checks
    // ****************************************
    post_fire_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
        post_active && post_run && post_tick && post_cnt_reg == 11'h001 |=> sys_reset)
        else $error("Boot watchdog expiry gave no reset.");
    post_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
        !post_active |=> post_cnt_reg == post_secs($past(cfg.post_sel)) && !post_tick)
        else $error("Boot watchdog counted outside self test.");
    pause_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        post_active && cfg.post_sel != 3'h0 && cfg.pause_en && user_wait
        |=> $stable(post_cnt_reg))
        else $error("Boot watchdog moved while paused.");
    onetime_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        rt_state_reg == RT_RUN && cfg.mode == MODE_ONE && retrigger |=> rt_state_reg == RT_OFF)
        else $error("One-time mode stayed armed after retrigger.");
    single_end_a: assert property (@(posedge clock) disable iff (!rst_n)
        expire && last_stage && cfg.mode == MODE_SINGLE |=> rt_state_reg == RT_OFF ##1 !expire)
        else $error("Single mode did not stop after last stage.");
    repeat_stay_a: assert property (@(posedge clock) disable iff (!rst_n)
        expire && last_stage && cfg.mode == MODE_REPEAT
        |=> runtime_active && $stable(stage_reg) && rt_cnt_reg == stage_tout(stage_reg, cfg))
        else $error("Repeat mode did not rerun last stage.");
    arm_start_a: assert property (@(posedge clock) disable iff (!rst_n)
        rt_state_reg == RT_OFF && os_boot_start && cfg.mode != MODE_OFF
        |=> rt_state_reg != RT_OFF && stage_reg == 2'h1)
        else $error("Runtime watchdog failed to arm.");
    stage_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
        expire && stage_reg == 2'h1 && cfg.event1 != ACT_ACPI && cfg.event1 != ACT_PWRBTN
        |=> sys_reset && !pwr_button)
        else $error("Stage one reset action missing.");
    acpi_route_a: assert property (@(posedge clock) disable iff (!rst_n)
        expire && stage_act(stage_reg, cfg) == ACT_ACPI
        |=> thermal_notify == !$past(cfg.acpi_restart) && fatal_error == $past(cfg.acpi_restart))
        else $error("ACPI action routed wrongly.");
    retrig_restart_a: assert property (@(posedge clock) disable iff (!rst_n)
        rt_state_reg == RT_RUN && retrigger && cfg.mode inside {MODE_SINGLE, MODE_REPEAT}
        |=> stage_reg == 2'h1 && rt_cnt_reg == stage_secs($past(cfg.tout1)))
        else $error("Retrigger did not restart stage one.");
    advance_a: assert property (@(posedge clock) disable iff (!rst_n)
        expire && !last_stage |=> stage_reg == 2'($past(stage_reg) + 2'h1))
        else $error("Stage did not advance on expiry.");
endmodule // staged_watchdog

// ===== design/wdt_defines.svh
// Offsets-free constants for the staged boot and runtime watchdog: timing and reset values.
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

`define CLOCK_HZ 200000000
`define TICK_PERIOD_MS 1000
`define SEC_TICK_CYCLES (`CLOCK_HZ / 1000 * `TICK_PERIOD_MS)

`define SECS_1S 11'h001
`define SECS_2S 11'h002
`define SECS_5S 11'h005
`define SECS_10S 11'h00A
`define SECS_30S 11'h01E
`define SECS_1M 11'h03C
`define SECS_2M 11'h078
`define SECS_5M 11'h12C
`define SECS_10M 11'h258
`define SECS_30M 11'h708

`define TOUT_SEL_DEFAULT 4'h4
`define DELAY_SEL_DEFAULT 3'h0
`define POST_SEL_DEFAULT 3'h0

`endif

// ===== design/wdt_pkg.sv
// Types shared by the staged watchdog modules.
package wdt_pkg;

    typedef enum logic [1:0] {
        ACT_OFF = 2'b00,
        ACT_ACPI = 2'b01,
        ACT_RESET = 2'b10,
        ACT_PWRBTN = 2'b11
    } act_t;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_ONE = 2'b01,
        MODE_SINGLE = 2'b10,
        MODE_REPEAT = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        RT_OFF = 2'b00,
        RT_DELAY = 2'b01,
        RT_RUN = 2'b10
    } rt_state_t;

    typedef struct packed {
        logic [2:0] post_sel;
        logic pause_en;
        mode_t mode;
        logic [2:0] delay_sel;
        act_t event1;
        act_t event2;
        act_t event3;
        logic [3:0] tout1;
        logic [3:0] tout2;
        logic [3:0] tout3;
        logic acpi_restart;
    } wdt_cfg_t;

endpackage

// ===== design/tick_divider.sv
// One-second enable pulse generator with a restart input.
`timescale 1ns/1ps
`include "wdt_defines.svh"
module tick_divider #(
    parameter int unsigned CYCLES = `SEC_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clear,
    output logic tick
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    if (CYCLES < 2) begin : g_bad
        $error("tick_divider needs at least two cycles per tick.");
    end

    always_comb begin
        cnt_next = cnt_reg + 32'h00000001;
        tick_next = 1'b0;
        if (clear) begin
            cnt_next = 32'h00000000;
        end else if (cnt_reg == 32'(CYCLES - 1)) begin
            cnt_next = 32'h00000000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule // tick_divider

// ===== verif/test_staged_watchdog.sv
// Self-checking bench for the staged boot and runtime watchdog.
`timescale 1ns/1ps
module test_staged_watchdog;
    import wdt_pkg::*;
    // ************************************************************
    // Signals and tables
    // ************************************************************
    localparam int T = 8;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    wdt_cfg_t cfg = '0;
    logic post_active = 1'b0;
    logic user_wait = 1'b0;
    logic os_boot_start = 1'b0;
    logic retrigger = 1'b0;
    logic sys_reset, pwr_button, thermal_notify, fatal_error, runtime_active;
    logic [1:0] stage;
    logic [4:0] v;
    int err_count = 0;
    int n_tests = 0;
    int n;
    int seen [4] = '{0, 0, 0, 0};
    int tsec [11] = '{1, 2, 5, 10, 30, 60, 120, 300, 600, 1800, 30};
    int psec [8] = '{0, 30, 60, 120, 300, 600, 1800, 1800};
    int dsec [8] = '{0, 10, 30, 60, 120, 300, 600, 1800};
    act_t ev [5] = '{ACT_ACPI, ACT_ACPI, ACT_RESET, ACT_PWRBTN, ACT_OFF};
    logic rs [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [3:0] ex [5] = '{4'h2, 4'h1, 4'h8, 4'h4, 4'h8};

    staged_watchdog #(.TICK_CYCLES(T)) dut (.clock(clock), .rst_n(rst_n), .cfg(cfg),
        .post_active(post_active), .user_wait(user_wait), .os_boot_start(os_boot_start),
        .retrigger(retrigger), .sys_reset(sys_reset), .pwr_button(pwr_button),
        .thermal_notify(thermal_notify), .fatal_error(fatal_error),
        .runtime_active(runtime_active), .stage(stage));

    initial begin
        forever #2.5 clock = ~clock;
    end

    // Pulses are counted so that a scenario can prove that none came out.
    always @(negedge clock) begin
        if (sys_reset === 1'b1) seen[0]++;
        if (pwr_button === 1'b1) seen[1]++;
        if (thermal_notify === 1'b1) seen[2]++;
        if (fatal_error === 1'b1) seen[3]++;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask

    // A few cycles of slack cover the divider restart and the output register.
    task automatic check_win(input string name, input int exp, input int got);
        n_tests++;
        if (got < exp - 1 || got > exp + 3) begin
            err_count++;
            $display("unexpected %s: expected %0d cycles, seen %0d", name, exp, got);
        end
    endtask

    task automatic wait_for(input logic [4:0] mask, input int lim, output int cnt);
        cnt = 0;
        v = 5'h00;
        while ((v & mask) == 5'h00) begin
            @(negedge clock);
            cnt++;
            v = {sys_reset, pwr_button, thermal_notify, fatal_error, runtime_active};
            if (cnt > lim) begin
                err_count++;
                $display("unexpected wait: expected an output, seen none");
                finish_test();
            end
        end
    endtask

    task automatic strobe(input bit arm);
        @(negedge clock);
        if (arm) os_boot_start = 1'b1;
        else retrigger = 1'b1;
        @(negedge clock);
        os_boot_start = 1'b0;
        retrigger = 1'b0;
    endtask

    task automatic arm_run();
        strobe(1'b1);
        @(negedge clock);
        check("armed", 32'h1, runtime_active);
        check("stage", 32'h1, stage);
    endtask

    task automatic step(input int secs, input logic [3:0] exp_v, input logic [1:0] exp_s);
        wait_for(5'h1E, secs * T + 20, n);
        check_win("stage time", secs * T, n);
        check("actions", exp_v, v[4:1]);
        check("stage", exp_s, stage);
    endtask

    task automatic do_reset(input int cyc);
        @(negedge clock);
        rst_n = 1'b0;
        cfg = '0;
        cfg.pause_en = 1'b1;
        cfg.event1 = ACT_RESET;
        cfg.tout1 = 4'h4;
        cfg.tout2 = 4'h4;
        cfg.tout3 = 4'h4;
        post_active = 1'b0;
        user_wait = 1'b0;
        repeat (cyc) @(negedge clock);
        rst_n = 1'b1;
        check("reset outputs", 32'h0, {runtime_active, stage});
        seen = '{0, 0, 0, 0};
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        void'($urandom(83752));
        do_reset(20);
        strobe(1'b1);
        repeat (300) @(negedge clock);
        check("disabled runtime", 32'h0, {runtime_active, stage, seen[0] != 0});
        $display("test mode_off done");
        cfg.mode = MODE_SINGLE;
        for (int k = 0; k < 11; k++) begin
            cfg.tout1 = 4'(k);
            arm_run();
            step(tsec[k], 4'h8, 2'h0);
            check("disarmed", 32'h0, runtime_active);
        end
        $display("test timeouts done");
        cfg.tout1 = 4'h0;
        for (int i = 0; i < 5; i++) begin
            cfg.event1 = ev[i];
            cfg.acpi_restart = rs[i];
            arm_run();
            step(1, ex[i], 2'h0);
        end
        $display("test actions done");
        cfg = '{post_sel: 3'h0, pause_en: 1'b1, mode: MODE_SINGLE, delay_sel: 3'h0,
            event1: ACT_ACPI, event2: ACT_PWRBTN, event3: ACT_RESET, tout1: 4'h0,
            tout2: 4'h1, tout3: 4'h2, acpi_restart: 1'($urandom % 2)};
        arm_run();
        step(1, cfg.acpi_restart ? 4'h1 : 4'h2, 2'h2);
        step(2, 4'h4, 2'h3);
        step(5, 4'h8, 2'h0);
        $display("test single_three done");
        cfg.mode = MODE_REPEAT;
        cfg.event1 = ACT_RESET;
        cfg.event3 = ACT_OFF;
        cfg.tout2 = 4'h0;
        arm_run();
        step(1, 4'h8, 2'h2);
        step(1, 4'h4, 2'h2);
        step(1, 4'h4, 2'h2);
        check("repeat active", 32'h1, runtime_active);
        strobe(1'b0);
        check("repeat kick", 32'h1, stage);
        do_reset(3);
        check("repeat ends", 32'h0, {runtime_active, stage});
        $display("test repeat done");
        cfg.mode = MODE_SINGLE;
        cfg.tout1 = 4'h1;
        arm_run();
        repeat (3 + $urandom % 4) begin
            repeat ($urandom % 10) @(negedge clock);
            strobe(1'b0);
        end
        check("kicked no action", 32'h0, seen[0]);
        check("kicked stage", 32'h1, stage);
        @(negedge clock);
        step(2, 4'h8, 2'h0);
        cfg.mode = MODE_ONE;
        arm_run();
        repeat (5) @(negedge clock);
        strobe(1'b0);
        @(negedge clock);
        check("one-time off", 32'h0, {runtime_active, stage});
        repeat (40) @(negedge clock);
        check("one-time quiet", 32'h1, seen[0]);
        $display("test retrigger done");
        cfg.mode = MODE_SINGLE;
        for (int d = 1; d < 8; d++) begin
            cfg.delay_sel = 3'(d);
            strobe(1'b1);
            strobe(1'b0);
            wait_for(5'h01, dsec[d] * T + 20, n);
            check_win("delay", dsec[d] * T, n + 2);
            check("after delay", 32'h1, stage);
            cfg.mode = MODE_OFF;
            @(negedge clock);
            cfg.mode = MODE_SINGLE;
        end
        $display("test delay done");
        do_reset(4);
        post_active = 1'b1;
        repeat (300) @(negedge clock);
        check("boot off", 32'h0, seen[0]);
        for (int p = 1; p < 8; p++) begin
            @(negedge clock);
            post_active = 1'b0;
            cfg.post_sel = 3'(p);
            cfg.pause_en = (p == 1);
            user_wait = 1'b1;
            // The timer loads its length while self test is off, so the selector settles first.
            @(negedge clock);
            post_active = 1'b1;
            if (p == 1) begin
                repeat (300) @(negedge clock);
                check("boot paused", 32'h0, seen[0]);
                user_wait = 1'b0;
            end
            if (p == 2) begin
                repeat (200) @(negedge clock);
                post_active = 1'b0;
                @(negedge clock);
                post_active = 1'b1;
            end
            wait_for(5'h10, psec[p] * T + 20, n);
            post_active = 1'b0;
            check_win("boot timeout", psec[p] * T, n);
            check("boot action", 32'h8, v[4:1]);
        end
        $display("test boot done");
        finish_test();
    end
endmodule // test_staged_watchdog
